// File: hdl/ptd_cfg.svh
// Constants for the post-trigger delay counter: register map, fields, resets and timing.
// Functional notes
// - A zero delay count starts acquisition right after the trigger, without waiting.
// - Timebase code -1,1,2,3,4,5 selects 200 ns,1 us,10 us,100 us,1 ms,10 ms.
// - The timebase code is ignored whenever the delay count is zero.
// - After reset no delay is programmed, so acquisition follows the trigger.
// - Sample-clock variant needs code zero; ticks are sample timebase over sample_divider.
// - Reset selects sample timebase code 1 with a sample_divider of 1.
// - In pretrigger mode a new delay is refused, kept zero, and a warning raised.
// - Selecting pretrigger mode with a delay programmed clears it and flags an error.
`ifndef PTD_CFG_SVH
`define PTD_CFG_SVH

// Register byte offsets on the APB.
`define PTD_OFF_CTRL 8'h00
`define PTD_OFF_DELAY 8'h04
`define PTD_OFF_RATE 8'h08
`define PTD_OFF_STATUS 8'h0C
`define PTD_OFF_MASK 8'h10
`define PTD_OFF_COUNT 8'h14

// Field positions.
`define PTD_CTRL_PRETRIG 0
`define PTD_CTRL_VARIANT 1
`define PTD_CODE_LSB 16
`define PTD_ST_WARN 0
`define PTD_ST_ERR 1
`define PTD_ST_BAD 2
`define PTD_ST_DONE 3
`define PTD_ST_BUSY 8

// Reset values.
`define PTD_RST_DELAY 16'h0000
`define PTD_RST_DCODE 3'h1
`define PTD_RST_RCODE 3'h1
`define PTD_RST_DIV 16'h0001
`define PTD_RST_MASK 4'h0

// Timebase codes; -1 is held as all ones in three bits.
`define PTD_TB_NONE 3'h0
`define PTD_TB_200NS 3'h7
`define PTD_TB_1US 3'h1
`define PTD_TB_10US 3'h2
`define PTD_TB_100US 3'h3
`define PTD_TB_1MS 3'h4
`define PTD_TB_10MS 3'h5

// Smallest nonzero delay count.
`define PTD_MIN_DELAY 16'h0003

// Tick periods in ns, and cycles at the core clock rate in MHz.
`define PTD_CLK_MHZ 20
`define PTD_T_200NS 200
`define PTD_T_1US 1000
`define PTD_T_10US 10000
`define PTD_T_100US 100000
`define PTD_T_1MS 1000000
`define PTD_T_10MS 10000000
`define PTD_CYC(ns) (((ns) * `PTD_CLK_MHZ) / 1000)

`endif

// File: hdl/ptd_delay_counter.sv
// Post-trigger delay counter with APB registers and a masked interrupt.
`timescale 1ns/1ps
`include "ptd_cfg.svh"
module ptd_delay_counter #(
   parameter logic [17:0] P_1MS_CYC = 18'(`PTD_CYC(`PTD_T_1MS)),
   parameter logic [17:0] P_10MS_CYC = 18'(`PTD_CYC(`PTD_T_10MS))
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB slave
   input wire ptd_pkg::ptd_apb_req_t apb_req,
   output ptd_pkg::ptd_apb_rsp_t apb_rsp,
   // Trigger and acquisition sequencing
   input wire logic trig_in,
   output logic acq_start,
   output logic busy,
   // Interrupt
   output logic irq
);
   import ptd_pkg::*;

   ptd_state_t state_r;
   logic pretrig_r;
   logic variant_r;
   logic [15:0] delay_count_r;
   ptd_code_t delay_code_r;
   ptd_code_t rate_code_r;
   logic [15:0] sample_divider_r;
   logic [3:0] status_r;
   logic [3:0] mask_r;
   logic acq_start_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_mux;
   logic [15:0] cnt_value;
   logic tick;
   logic wr;
   logic mapped;
   logic wr_ctrl;
   logic wr_delay;
   logic wr_rate;
   logic wr_status;
   logic wr_mask;
   logic [15:0] new_cnt;
   ptd_code_t new_code;
   logic code_ok;
   logic cnt_ok;
   logic delay_refused;
   logic delay_bad;
   logic delay_accept;
   logic rate_accept;
   logic rate_bad;
   logic pre_clear;
   logic start_now;
   logic load;
   logic terminal;
   logic [3:0] status_set;
   ptd_code_t tick_code;
   logic [15:0] tick_div;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic own_code_valid(input ptd_code_t c);
      own_code_valid = (c == `PTD_TB_200NS) || (c >= `PTD_TB_1US && c <= `PTD_TB_10MS);
   endfunction

   // APB decode; the slave never inserts wait states.
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign mapped = hit(apb_req.paddr, `PTD_OFF_CTRL) || hit(apb_req.paddr, `PTD_OFF_DELAY)
      || hit(apb_req.paddr, `PTD_OFF_RATE) || hit(apb_req.paddr, `PTD_OFF_STATUS)
      || hit(apb_req.paddr, `PTD_OFF_MASK) || hit(apb_req.paddr, `PTD_OFF_COUNT);
   assign wr_ctrl = wr && hit(apb_req.paddr, `PTD_OFF_CTRL);
   assign wr_delay = wr && hit(apb_req.paddr, `PTD_OFF_DELAY);
   assign wr_rate = wr && hit(apb_req.paddr, `PTD_OFF_RATE);
   assign wr_status = wr && hit(apb_req.paddr, `PTD_OFF_STATUS);
   assign wr_mask = wr && hit(apb_req.paddr, `PTD_OFF_MASK);

   assign new_cnt = apb_req.pwdata[15:0];
   assign new_code = apb_req.pwdata[`PTD_CODE_LSB +: 3];

   // The sample-clock variant only takes code zero; the own timebase refuses reserved codes.
   assign code_ok = variant_r ? (new_code == `PTD_TB_NONE) : own_code_valid(new_code);
   // Counts of 1 and 2 are refused rather than trusted, since the counter cannot honour them.
   assign cnt_ok = (new_cnt == 16'h0000) || (new_cnt >= `PTD_MIN_DELAY);
   assign delay_refused = wr_delay && pretrig_r;
   // A zero count is accepted whatever code comes with it.
   assign delay_bad = wr_delay && !pretrig_r
      && !(cnt_ok && (new_cnt == 16'h0000 || code_ok));
   assign delay_accept = wr_delay && !pretrig_r && !delay_bad;
   assign rate_accept = wr_rate && own_code_valid(new_code) && new_cnt != 16'h0000;
   assign rate_bad = wr_rate && !rate_accept;
   assign pre_clear = wr_ctrl && apb_req.pwdata[`PTD_CTRL_PRETRIG]
      && delay_count_r != 16'h0000;

   // Control register.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pretrig_r <= 1'b0;
         variant_r <= 1'b0;
      end else if (wr_ctrl) begin
         pretrig_r <= apb_req.pwdata[`PTD_CTRL_PRETRIG];
         variant_r <= apb_req.pwdata[`PTD_CTRL_VARIANT];
      end
   end

   // Delay setting.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         delay_count_r <= `PTD_RST_DELAY;
         delay_code_r <= `PTD_RST_DCODE;
      end else if (pre_clear) begin
         delay_count_r <= 16'h0000;
      end else if (delay_accept) begin
         delay_count_r <= new_cnt;
         delay_code_r <= new_code;
      end else if (delay_refused) begin
         delay_count_r <= 16'h0000;
      end
   end

   // Sampling rate setting.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rate_code_r <= `PTD_RST_RCODE;
         sample_divider_r <= `PTD_RST_DIV;
      end else if (rate_accept) begin
         rate_code_r <= new_code;
         sample_divider_r <= new_cnt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mask_r <= `PTD_RST_MASK;
      end else if (wr_mask) begin
         mask_r <= apb_req.pwdata[3:0];
      end
   end

   // Tick source: own timebase, or the sample timebase divided by sample_divider.
   assign tick_code = variant_r ? rate_code_r : delay_code_r;
   assign tick_div = variant_r ? sample_divider_r : 16'h0001;

   // A trigger in the cycle that clears the delay starts at once; no stale count is loaded.
   assign start_now = (state_r == PTD_ST_IDLE) && trig_in
      && (delay_count_r == 16'h0000 || pre_clear);
   assign load = (state_r == PTD_ST_IDLE) && trig_in && delay_count_r != 16'h0000
      && !pre_clear;
   assign terminal = (state_r == PTD_ST_COUNT) && tick && cnt_value == 16'h0001;

   ptd_tick_gen #(
      .P_1MS_CYC(P_1MS_CYC),
      .P_10MS_CYC(P_10MS_CYC)
   ) u_tick (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .restart(load),
      .code(tick_code),
      .div(tick_div),
      .tick(tick)
   );

   ptd_down_counter u_count (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(load),
      .load_val(delay_count_r),
      .dec((state_r == PTD_ST_COUNT) && tick),
      .value_r(cnt_value)
   );

   // Sequencer; triggers that arrive while counting are ignored.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= PTD_ST_IDLE;
      end else begin
         case (state_r)
            PTD_ST_IDLE: begin
               if (load) begin
                  state_r <= PTD_ST_COUNT;
               end
            end
            PTD_ST_COUNT: begin
               if (terminal || pre_clear) begin
                  state_r <= PTD_ST_IDLE;
               end
            end
            default: state_r <= PTD_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         acq_start_r <= 1'b0;
      end else begin
         acq_start_r <= start_now || (terminal && !pre_clear);
      end
   end

   // Sticky events; a new event wins over a write-one clear in the same cycle.
   assign status_set = {acq_start_r, delay_bad || rate_bad, pre_clear, delay_refused};
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_r <= 4'h0;
      end else begin
         status_r <= (status_r & ~(wr_status ? apb_req.pwdata[3:0] : 4'h0))
            | status_set;
      end
   end

   // Read data is captured in the setup phase so prdata comes from a flip-flop.
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (apb_req.paddr)
         `PTD_OFF_CTRL: rd_mux = {30'h0, variant_r, pretrig_r};
         `PTD_OFF_DELAY: rd_mux = {13'h0, delay_code_r, delay_count_r};
         `PTD_OFF_RATE: rd_mux = {13'h0, rate_code_r, sample_divider_r};
         `PTD_OFF_STATUS: rd_mux = {23'h0, busy, 4'h0, status_r};
         `PTD_OFF_MASK: rd_mux = {28'h000_0000, mask_r};
         `PTD_OFF_COUNT: rd_mux = {16'h0000, cnt_value};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (apb_req.psel && !apb_req.penable) begin
         prdata_r <= rd_mux;
      end
   end

   assign apb_rsp.prdata = prdata_r;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
   assign acq_start = acq_start_r;
   assign busy = (state_r == PTD_ST_COUNT);
   assign irq = |(status_r & mask_r);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_zero_delay;
      trig_in && !busy && delay_count_r == 16'h0000 && !pre_clear |=> acq_start;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not start");

   property p_zero_ignores_code;
      wr_delay && !pretrig_r && new_cnt == 16'h0000 && !pre_clear
         |=> delay_count_r == 16'h0000 && !$rose(status_r[`PTD_ST_BAD]);
   endproperty
   a_zero_ignores_code: assert property (p_zero_ignores_code) else $error("zero refused");

   property p_reset_delay;
      $past(sys_rst) |-> delay_count_r == 16'h0000 && rate_code_r == `PTD_TB_1US
         && sample_divider_r == 16'h0001;
   endproperty
   a_reset_delay: assert property (p_reset_delay) else $error("bad reset defaults");

   property p_reset_rate;
      $past(sys_rst) ##1 !wr_rate |-> sample_divider_r == 16'h0001;
   endproperty
   a_reset_rate: assert property (p_reset_rate) else $error("sample divider lost");

   property p_variant_code;
      wr_delay && !pretrig_r && variant_r && new_code != 3'h0 && new_cnt != 16'h0000
         |=> $stable(delay_count_r) && status_r[`PTD_ST_BAD];
   endproperty
   a_variant_code: assert property (p_variant_code) else $error("variant code taken");

   property p_pretrig_refuse;
      wr_delay && pretrig_r |=> delay_count_r == 16'h0000 && status_r[`PTD_ST_WARN];
   endproperty
   a_pretrig_refuse: assert property (p_pretrig_refuse) else $error("delay not refused");

   property p_pretrig_clear;
      wr_ctrl && apb_req.pwdata[0] && delay_count_r != 16'h0000
         |=> delay_count_r == 16'h0000 && status_r[`PTD_ST_ERR] && !busy;
   endproperty
   a_pretrig_clear: assert property (p_pretrig_clear) else $error("delay not cleared");

   property p_load;
      load && !pre_clear |=> busy && cnt_value == $past(delay_count_r);
   endproperty
   a_load: assert property (p_load) else $error("count not loaded");

   property p_terminal;
      terminal && !pre_clear |=> acq_start && !busy ##1 (!acq_start || $past(trig_in));
   endproperty
   a_terminal: assert property (p_terminal) else $error("terminal count missed");

   property p_count_range;
      wr_delay && !pretrig_r && new_cnt != 16'h0000 && new_cnt < `PTD_MIN_DELAY
         |=> $stable(delay_count_r) && status_r[`PTD_ST_BAD];
   endproperty
   a_count_range: assert property (p_count_range) else $error("count 1 or 2 taken");

   property p_reserved_code;
      wr_delay && !pretrig_r && !variant_r && new_cnt != 16'h0000 && new_code == `PTD_TB_NONE
         |=> $stable(delay_count_r) && status_r[`PTD_ST_BAD];
   endproperty
   a_reserved_code: assert property (p_reserved_code) else $error("code 0 taken");

   property p_pretrig_zero;
      pretrig_r |-> delay_count_r == 16'h0000;
   endproperty
   a_pretrig_zero: assert property (p_pretrig_zero) else $error("delay kept");

   property p_rate_bad;
      wr_rate && (new_cnt == 16'h0000 || !own_code_valid(new_code))
         |=> $stable(sample_divider_r) && $stable(rate_code_r) && status_r[`PTD_ST_BAD];
   endproperty
   a_rate_bad: assert property (p_rate_bad) else $error("bad rate taken");

   property p_busy_hold;
      busy && !terminal && !pre_clear |=> busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("count ended early");

   property p_idle_hold;
      !busy && !load |=> !busy;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("count began untriggered");

   property p_count_dec;
      busy && tick && !terminal |=> cnt_value == $past(cnt_value) - 16'h0001;
   endproperty
   a_count_dec: assert property (p_count_dec) else $error("tick not counted");

   property p_count_hold;
      busy && !tick |=> $stable(cnt_value);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved off tick");

   property p_sticky;
      !wr_status |=> (status_r & $past(status_r)) == $past(status_r);
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit dropped");

   c_delayed_start: cover property (busy ##1 acq_start);
   c_warning: cover property ($rose(status_r[`PTD_ST_WARN]));
   c_cleared: cover property ($rose(status_r[`PTD_ST_ERR]));
   c_irq: cover property ($rose(irq));
   c_variant_start: cover property (variant_r && busy ##1 acq_start);
endmodule

// File: hdl/ptd_down_counter.sv
// Loadable 16-bit down counter for the delay.
`timescale 1ns/1ps
module ptd_down_counter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic dec,
   // State
   output logic [15:0] value_r
);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         value_r <= 16'h0000;
      end else if (load) begin
         value_r <= load_val;
      end else if (dec && value_r != 16'h0000) begin
         value_r <= value_r - 16'h0001;
      end
   end
endmodule

// File: hdl/ptd_pkg.sv
// Types shared by the post-trigger delay counter files.
package ptd_pkg;
   typedef logic [2:0] ptd_code_t;

   typedef enum logic [1:0] {
      PTD_ST_IDLE = 2'b01,
      PTD_ST_COUNT = 2'b10
   } ptd_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ptd_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ptd_apb_rsp_t;
endpackage

// File: hdl/ptd_tick_gen.sv
// Timebase tick generator: period from a code, stretched by a divider.
`timescale 1ns/1ps
`include "ptd_cfg.svh"
module ptd_tick_gen #(
   parameter logic [17:0] P_1MS_CYC = 18'(`PTD_CYC(`PTD_T_1MS)),
   parameter logic [17:0] P_10MS_CYC = 18'(`PTD_CYC(`PTD_T_10MS))
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control
   input wire logic restart,
   input wire ptd_pkg::ptd_code_t code,
   input wire logic [15:0] div,
   // Tick enable
   output logic tick
);
   import ptd_pkg::*;

   logic [17:0] pre_r;
   logic [15:0] div_r;
   logic [17:0] period;
   logic [15:0] div_eff;
   logic pre_end;
   logic div_end;

   function automatic logic [17:0] tb_period(input ptd_code_t c);
      case (c)
         `PTD_TB_200NS: tb_period = 18'(`PTD_CYC(`PTD_T_200NS));
         `PTD_TB_1US: tb_period = 18'(`PTD_CYC(`PTD_T_1US));
         `PTD_TB_10US: tb_period = 18'(`PTD_CYC(`PTD_T_10US));
         `PTD_TB_100US: tb_period = 18'(`PTD_CYC(`PTD_T_100US));
         `PTD_TB_1MS: tb_period = P_1MS_CYC;
         `PTD_TB_10MS: tb_period = P_10MS_CYC;
         default: tb_period = 18'h0_0001;
      endcase
   endfunction

   assign period = tb_period(code);
   assign div_eff = (div == 16'h0000) ? 16'h0001 : div;
   // Compare with >= so a code change mid-period cannot strand the prescaler.
   assign pre_end = (pre_r >= period - 18'h0_0001);
   assign div_end = (div_r >= div_eff - 16'h0001);
   assign tick = pre_end && div_end && !restart;

   always_ff @(posedge core_clk) begin
      if (sys_rst || restart || pre_end) begin
         pre_r <= 18'h0_0000;
      end else begin
         pre_r <= pre_r + 18'h0_0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || restart) begin
         div_r <= 16'h0000;
      end else if (pre_end) begin
         div_r <= div_end ? 16'h0000 : div_r + 16'h0001;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_tb_200ns;
      restart && code == `PTD_TB_200NS && div_eff == 16'h0001 ##1 !restart [*3]
         |-> ##1 (tick || restart);
   endproperty
   a_tb_200ns: assert property (p_tb_200ns) else $error("200 ns tick not on 4th cycle");

   property p_tb_1us;
      restart && code == `PTD_TB_1US && div_eff == 16'h0001 |-> !tick [*8];
   endproperty
   a_tb_1us: assert property (p_tb_1us) else $error("1 us tick came too early");
endmodule

// File: tb/ptd_acq_seq.sv
// Behavioural trigger source and acquisition timer facing the delay counter.
`timescale 1ns/1ps
module ptd_acq_seq (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Bench request
   input wire logic go,
   // Device side
   input wire logic acq_start,
   input wire logic busy,
   output logic trig_in = 1'h0,
   // Measurement
   output logic [31:0] lat = 32'h0000_0000,
   output logic done = 1'h0
);
   logic run_r = 1'h0;
   logic [31:0] cnt_r = 32'h0000_0000;

   // A held request toggles trig_in, so it gives a one-cycle pulse on every other cycle.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         trig_in <= 1'h0;
      end else begin
         trig_in <= go & ~trig_in;
      end
   end

   // Edges are counted from the one that takes the trigger to the one that sees the start.
   always @(posedge core_clk) begin
      if (sys_rst) begin
         run_r <= 1'h0;
         done <= 1'h0;
      end else if (trig_in && !busy) begin
         run_r <= 1'h1;
         cnt_r <= 32'h0000_0001;
         done <= 1'h0;
      end else if (run_r) begin
         if (acq_start) begin
            run_r <= 1'h0;
            lat <= cnt_r;
            done <= 1'h1;
         end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
         end
      end
   end
endmodule

// File: tb/ptd_delay_counter_test.sv
// Self-checking bench for the post-trigger delay counter.
`timescale 1ns/1ps
`include "ptd_cfg.svh"
module ptd_delay_counter_test;
   import ptd_pkg::*;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic go = 1'h0;
   ptd_apb_req_t apb_req = '0;
   ptd_apb_rsp_t apb_rsp;
   logic trig_in;
   logic acq_start;
   logic busy;
   logic irq;
   logic done;
   logic [31:0] lat;
   logic [31:0] rd;
   logic err;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   localparam logic [2:0] CODES [6] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
   // Cycles per tick, with the millisecond bases shortened to 40 and 80.
   localparam int PER [6] = '{4, 20, 200, 2000, 40, 80};
   localparam logic [31:0] BAD [3] = '{32'h0007_0001, 32'h0007_0002, 32'h0000_0003};

   always #25 core_clk = ~core_clk;

   ptd_delay_counter #(.P_1MS_CYC(18'h0_0028), .P_10MS_CYC(18'h0_0050)) dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .trig_in(trig_in), .acq_start(acq_start), .busy(busy), .irq(irq));

   ptd_acq_seq model (
      .core_clk(core_clk), .sys_rst(sys_rst), .go(go), .acq_start(acq_start),
      .busy(busy), .trig_in(trig_in), .lat(lat), .done(done));

   task automatic finish_test();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge core_clk);
      apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: addr, pwdata: wd};
      @(posedge core_clk);
      apb_req.penable <= 1'h1;
      // Only the bench timeout ends a wait for the slave.
      do begin
         @(posedge core_clk);
      end while (apb_rsp.pready !== 1'h1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0000_0000);
      check(rd, e);
   endtask

   // The status and mask registers must settle before the interrupt line is judged.
   task automatic irq_is(input logic e);
      repeat (2) @(posedge core_clk);
      #1;
      check(32'(irq), 32'(e));
   endtask

   task automatic fire(input logic [31:0] exp_lat);
      @(posedge core_clk);
      go <= 1'h1;
      @(posedge core_clk);
      go <= 1'h0;
      @(posedge core_clk);
      #1;
      check(32'(busy), 32'(exp_lat > 32'h0000_0001));
      while (done !== 1'h1) begin
         @(posedge core_clk);
      end
      check(lat, exp_lat);
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'h0;
      rchk(`PTD_OFF_CTRL, 32'h0000_0000);
      rchk(`PTD_OFF_DELAY, 32'h0001_0000);
      rchk(`PTD_OFF_RATE, 32'h0001_0001);
      rchk(`PTD_OFF_STATUS, 32'h0000_0000);
      rchk(`PTD_OFF_MASK, 32'h0000_0000);
      rchk(8'h18, 32'h0000_0000);
      check(32'(err), 32'h0000_0001);
      fire(32'h0000_0001);
      $display("test reset done");
      wr(`PTD_OFF_DELAY, 32'h0005_0000);
      fire(32'h0000_0001);
      wr(`PTD_OFF_DELAY, 32'h0000_0000);
      fire(32'h0000_0001);
      $display("test zero delay done");
      for (int i = 0; i < 6; i++) begin
         wr(`PTD_OFF_DELAY, {13'h0, CODES[i], 16'h0003});
         fire(32'(3 * PER[i] + 1));
      end
      $display("test timebase done");
      wr(`PTD_OFF_STATUS, 32'h0000_000F);
      for (int i = 0; i < 3; i++) begin
         wr(`PTD_OFF_DELAY, BAD[i]);
         rchk(`PTD_OFF_DELAY, 32'h0005_0003);
         rchk(`PTD_OFF_STATUS, 32'h0000_0004);
         wr(`PTD_OFF_STATUS, 32'h0000_000F);
      end
      wr(`PTD_OFF_DELAY, 32'h0007_FFFF);
      rchk(`PTD_OFF_DELAY, 32'h0007_FFFF);
      $display("test count range done");
      wr(`PTD_OFF_CTRL, 32'h0000_0002);
      wr(`PTD_OFF_RATE, 32'h0001_0002);
      wr(`PTD_OFF_DELAY, 32'h0000_0003);
      rchk(`PTD_OFF_DELAY, 32'h0000_0003);
      fire(32'h0000_0079);
      rchk(`PTD_OFF_COUNT, 32'h0000_0000);
      wr(`PTD_OFF_DELAY, 32'h0001_0003);
      rchk(`PTD_OFF_STATUS, 32'h0000_000C);
      wr(`PTD_OFF_STATUS, 32'h0000_000F);
      wr(`PTD_OFF_RATE, 32'h0001_0000);
      rchk(`PTD_OFF_RATE, 32'h0001_0002);
      rchk(`PTD_OFF_STATUS, 32'h0000_0004);
      wr(`PTD_OFF_STATUS, 32'h0000_000F);
      wr(`PTD_OFF_CTRL, 32'h0000_0000);
      $display("test sample variant done");
      wr(`PTD_OFF_DELAY, 32'h0007_0003);
      wr(`PTD_OFF_CTRL, 32'h0000_0001);
      rchk(`PTD_OFF_STATUS, 32'h0000_0002);
      apb(1'h0, `PTD_OFF_DELAY, 32'h0000_0000);
      check({16'h0000, rd[15:0]}, 32'h0000_0000);
      wr(`PTD_OFF_DELAY, 32'h0007_0005);
      rchk(`PTD_OFF_STATUS, 32'h0000_0003);
      apb(1'h0, `PTD_OFF_DELAY, 32'h0000_0000);
      check({16'h0000, rd[15:0]}, 32'h0000_0000);
      fire(32'h0000_0001);
      wr(`PTD_OFF_STATUS, 32'h0000_000F);
      wr(`PTD_OFF_CTRL, 32'h0000_0000);
      $display("test pretrigger done");
      wr(`PTD_OFF_DELAY, 32'h0000_0000);
      wr(`PTD_OFF_MASK, 32'h0000_0008);
      fire(32'h0000_0001);
      irq_is(1'h1);
      wr(`PTD_OFF_STATUS, 32'h0000_0008);
      irq_is(1'h0);
      wr(`PTD_OFF_MASK, 32'h0000_0000);
      fire(32'h0000_0001);
      irq_is(1'h0);
      rchk(`PTD_OFF_STATUS, 32'h0000_0008);
      $display("test interrupt done");
      // A board reset while idle, just after a new delay is written, must bring back the delay and rate defaults.
      wr(`PTD_OFF_DELAY, 32'h0002_0009);
      @(posedge core_clk);
      sys_rst <= 1'h1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'h0;
      rchk(`PTD_OFF_DELAY, 32'h0001_0000);
      rchk(`PTD_OFF_RATE, 32'h0001_0001);
      fire(32'h0000_0001);
      $display("test board reset done");
      finish_test();
   end
endmodule
